// >>> ssf_pkg.sv
// Purpose: Shared constants and types of the SPI status block, plus its occupancy counter.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   The counter tracks how many valid bytes a four-byte FIFO holds.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package ssf_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned LVL_W  = 3;
    localparam int unsigned THR_W  = 2;
    localparam int unsigned IRQ_W  = 4;
    localparam int unsigned BE_W   = 4;

    localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'ha00;
    localparam logic [ADDR_W-1:0] OFF_RXDATA   = 12'ha04;
    localparam logic [ADDR_W-1:0] OFF_TXDATA   = 12'ha08;
    localparam logic [ADDR_W-1:0] OFF_CONTROL  = 12'ha10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'ha20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'ha24;

    localparam int unsigned CTL_THR_LSB    = 14;
    localparam int unsigned CTL_TFLUSH_BIT = 13;
    localparam int unsigned CTL_RFLUSH_BIT = 12;
    localparam int unsigned CTL_TMODE_BIT  = 6;
    localparam logic [WORD_W-1:0] CTL_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] CTL_WMASK = 16'hf040;

    localparam logic [LVL_W-1:0] LVL_ZERO = 3'h0;
    localparam logic [LVL_W-1:0] LVL_ONE  = 3'h1;
    localparam logic [LVL_W-1:0] LVL_FULL = 3'h4;
    localparam logic [LVL_W-1:0] BIT_LAST = 3'h7;

    localparam int unsigned IRQ_RX  = 0;
    localparam int unsigned IRQ_TX  = 1;
    localparam int unsigned IRQ_OVF = 2;
    localparam int unsigned IRQ_UF  = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    typedef struct packed {
        logic [3:0]       reserved;
        logic             rx_excess_flag;
        logic [LVL_W-1:0] rx_fifo_level;
        logic             rx_overflow_flag;
        logic             rx_irq_flag;
        logic             tx_irq_flag;
        logic             tx_underflow_flag;
        logic [LVL_W-1:0] tx_fifo_level;
        logic             any_irq_flag;
    } ssf_status_s;

    typedef struct packed {
        logic [THR_W-1:0] irq_threshold_mode;
        logic             tx_flush_enable;
        logic             rx_flush_enable;
        logic             transfer_direction_mode;
    } ssf_ctrl_s;
endpackage : ssf_pkg

// ----------------------------------------------------------------------------
// Occupancy counter
// ----------------------------------------------------------------------------
module ssf_level_ctr
    import ssf_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             push_i,
    input  wire logic             pop_i,
    input  wire logic             flush_i,
    output logic [LVL_W-1:0]      level_o,
    output logic                  full_o,
    output logic                  empty_o
);
    import ssf_pkg::*;

    logic [LVL_W-1:0] level_q;
    logic             do_push;
    logic             do_pop;

    // A push into a full counter with no pop in the same cycle and a pop from an empty one are dropped.
    assign do_push = push_i && (level_q != LVL_FULL || pop_i);
    assign do_pop  = pop_i && (level_q != LVL_ZERO);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_q <= LVL_ZERO;
        end else if (flush_i) begin
            level_q <= LVL_ZERO;
        end else if (do_push && !do_pop) begin
            level_q <= level_q + LVL_ONE;
        end else if (do_pop && !do_push) begin
            level_q <= level_q - LVL_ONE;
        end
    end

    assign level_o = level_q;
    assign full_o  = (level_q == LVL_FULL);
    assign empty_o = (level_q == LVL_ZERO);
endmodule : ssf_level_ctr

// >>> ssf_status_flags.sv
// Purpose: Status word, event flags and interrupt logic of an SPI port.
// Assumes: Avalon-MM slave with one wait state; SPI clock idles low, bytes end on rising edges.
// Notes:   The serial shifter is not here; byte boundaries come from counting clock edges.
//
// Functional notes
// - Excess flag when rx level exceeds threshold.
// - Excess flag drops at or below threshold.
// - Rx level reported as 000 to 100.
// - Overflow flag on load into full rx.
// - Overflow interrupts unless rx flush enabled.
// - Rx irq flag at threshold, mode clear.
// - Tx irq flag after threshold bytes, mode set.
// - Underflow flag on start with empty tx.
// - Underflow interrupts unless tx flush enabled.
// - Status read clears four event flags.
// - Tx level reported as 000 to 100.
// - Summary flag on any event, read clears; underflow with tx flush enabled does not set it.
// - Two-bit field selects one to four bytes.
// - Rx flush discards data, no rx interrupts.
// - Status word is 16-bit read only.
//
// Added by the designer: the address map and the Avalon-MM slave port.

module ssf_status_flags
    import ssf_pkg::*;
(
    input  wire logic                    CLK_I,
    input  wire logic                    SYS_RST_I,
    input  wire logic [ssf_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                    AVS_READ_I,
    input  wire logic                    AVS_WRITE_I,
    input  wire logic [ssf_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
    input  wire logic [ssf_pkg::BE_W-1:0]   AVS_BYTEENABLE_I,
    output logic      [ssf_pkg::DATA_W-1:0] AVS_READDATA_O,
    output logic                         AVS_WAITREQUEST_O,
    input  wire logic                    SPI_SCLK_I,
    input  wire logic                    SPI_CS_N_I,
    output logic                         IRQ_O
);
    import ssf_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic                 ack_q;
    logic                 req;
    logic                 acc_rd;
    logic                 acc_wr;
    logic [DATA_W-1:0]    rdata_q;
    logic [WORD_W-1:0]    rd_mux;
    logic [WORD_W-1:0]    be_mask;
    logic [WORD_W-1:0]    ctl_q;
    ssf_ctrl_s            ctl;
    logic [IRQ_W-1:0]     irq_stat_q;
    logic [IRQ_W-1:0]     irq_mask_q;
    logic [IRQ_W-1:0]     irq_set;
    ssf_status_s          status;
    ssf_status_s          rd_status_q;

    logic [2:0]           sclk_sync_q;
    logic [1:0]           cs_sync_q;
    logic                 sclk_rise;
    logic [LVL_W-1:0]     bit_cnt_q;
    logic                 tx_start;
    logic                 byte_done;

    logic [LVL_W-1:0]     thr_cnt;
    logic [LVL_W-1:0]     rx_level;
    logic [LVL_W-1:0]     tx_level;
    logic                 rx_full;
    logic                 rx_empty;
    logic                 tx_full;
    logic                 tx_empty;
    logic                 rx_push;
    logic                 rx_pop;
    logic                 tx_push;
    logic                 tx_pop;
    logic [LVL_W-1:0]     tx_sent_q;

    logic                 ovf_q;
    logic                 rxirq_q;
    logic                 txirq_q;
    logic                 uf_q;
    logic                 any_q;
    logic                 ovf_evt;
    logic                 uf_evt;
    logic                 rxirq_evt;
    logic                 txirq_evt;
    logic                 stat_clr;

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    // Each access takes one wait state; side effects happen at the accepting edge.
    assign req               = AVS_READ_I || AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req && !ack_q;
    assign acc_rd            = AVS_READ_I && ack_q;
    assign acc_wr            = AVS_WRITE_I && ack_q;
    assign AVS_READDATA_O    = rdata_q;
    assign be_mask           = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (AVS_ADDRESS_I)
            OFF_STATUS:   rd_mux = status;
            OFF_CONTROL:  rd_mux = ctl_q;
            OFF_IRQ_STAT: rd_mux = {{(WORD_W-IRQ_W){1'b0}}, irq_stat_q};
            OFF_IRQ_MASK: rd_mux = {{(WORD_W-IRQ_W){1'b0}}, irq_mask_q};
            default:      rd_mux = '0;
        endcase
    end

    // Read data and the snapshot of the status word are taken in the wait cycle.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rdata_q     <= '0;
            rd_status_q <= '0;
        end else if (AVS_READ_I && !ack_q) begin
            rdata_q     <= {{(DATA_W-WORD_W){1'b0}}, rd_mux};
            rd_status_q <= status;
        end
    end

    // Status word and rx data register ignore writes.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctl_q <= CTL_RESET;
        end else if (acc_wr && AVS_ADDRESS_I == OFF_CONTROL) begin
            ctl_q <= (ctl_q & ~(be_mask & CTL_WMASK))
                   | (AVS_WRITEDATA_I[WORD_W-1:0] & be_mask & CTL_WMASK);
        end
    end

    assign ctl.irq_threshold_mode      = ctl_q[CTL_THR_LSB +: THR_W];
    assign ctl.tx_flush_enable         = ctl_q[CTL_TFLUSH_BIT];
    assign ctl.rx_flush_enable         = ctl_q[CTL_RFLUSH_BIT];
    assign ctl.transfer_direction_mode = ctl_q[CTL_TMODE_BIT];

    assign stat_clr = acc_rd && (AVS_ADDRESS_I == OFF_STATUS);
    assign rx_pop   = acc_rd && (AVS_ADDRESS_I == OFF_RXDATA);
    assign tx_push  = acc_wr && (AVS_ADDRESS_I == OFF_TXDATA) && AVS_BYTEENABLE_I[0]
                      && !ctl.tx_flush_enable;

    // ------------------------------------------------------------------------
    // Link clock sampling
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sclk_sync_q <= '0;
            cs_sync_q   <= 2'h3;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], SPI_SCLK_I};
            cs_sync_q   <= {cs_sync_q[0], SPI_CS_N_I};
        end
    end

    assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2] && !cs_sync_q[1];
    assign tx_start  = sclk_rise && (bit_cnt_q == LVL_ZERO);
    assign byte_done = sclk_rise && (bit_cnt_q == BIT_LAST);

    // The bit count restarts while select is high, so a cut frame leaves no partial byte.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bit_cnt_q <= LVL_ZERO;
        end else if (cs_sync_q[1]) begin
            bit_cnt_q <= LVL_ZERO;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + LVL_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // FIFO occupancy
    // ------------------------------------------------------------------------
    // The threshold field counts from zero, so the byte count is the field value plus one.
    assign thr_cnt = {1'b0, ctl.irq_threshold_mode} + LVL_ONE;
    assign rx_push = byte_done && !ctl.rx_flush_enable;
    assign tx_pop  = byte_done;

    ssf_level_ctr u_rx_level (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .push_i  (rx_push),
        .pop_i   (rx_pop),
        .flush_i (ctl.rx_flush_enable),
        .level_o (rx_level),
        .full_o  (rx_full),
        .empty_o (rx_empty)
    );

    ssf_level_ctr u_tx_level (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .push_i  (tx_push),
        .pop_i   (tx_pop),
        .flush_i (ctl.tx_flush_enable),
        .level_o (tx_level),
        .full_o  (tx_full),
        .empty_o (tx_empty)
    );

    // Counts bytes sent since the last transmit interrupt.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tx_sent_q <= LVL_ZERO;
        end else if (!ctl.transfer_direction_mode || txirq_evt) begin
            tx_sent_q <= LVL_ZERO;
        end else if (byte_done) begin
            tx_sent_q <= tx_sent_q + LVL_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------------
    // Overflow is a push into a full FIFO with no pop in the same cycle.
    // The rx interrupt compares the threshold against the level that the push produces.
    assign ovf_evt   = rx_push && rx_full && !rx_pop;
    assign uf_evt    = tx_start && tx_empty;
    assign rxirq_evt = rx_push && !rx_full && !ctl.transfer_direction_mode
                       && ((rx_level + LVL_ONE) >= thr_cnt);
    assign txirq_evt = byte_done && ctl.transfer_direction_mode
                       && ((tx_sent_q + LVL_ONE) >= thr_cnt);

    // A flag is cleared only if the status read reported it; a new event wins.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ovf_q   <= 1'b0;
            rxirq_q <= 1'b0;
            txirq_q <= 1'b0;
            uf_q    <= 1'b0;
        end else begin
            ovf_q   <= ovf_evt || (ovf_q && !(stat_clr && rd_status_q.rx_overflow_flag));
            rxirq_q <= rxirq_evt || (rxirq_q && !(stat_clr && rd_status_q.rx_irq_flag));
            txirq_q <= txirq_evt || (txirq_q && !(stat_clr && rd_status_q.tx_irq_flag));
            uf_q    <= uf_evt || (uf_q && !(stat_clr && rd_status_q.tx_underflow_flag));
        end
    end

    // The flush enables keep overflow and underflow from requesting an interrupt.
    assign irq_set[IRQ_RX]  = rxirq_evt;
    assign irq_set[IRQ_TX]  = txirq_evt;
    assign irq_set[IRQ_OVF] = ovf_evt && !ctl.rx_flush_enable;
    assign irq_set[IRQ_UF]  = uf_evt && !ctl.tx_flush_enable;

    // The summary flag follows every event that requests an interrupt.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            any_q <= 1'b0;
        end else begin
            any_q <= (|irq_set) || (any_q && !(stat_clr && rd_status_q.any_irq_flag));
        end
    end

    // ------------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------------
    // Excess is combinational from the level, so it drops as soon as a pop brings the level down to the threshold.
    assign status.reserved          = '0;
    assign status.rx_excess_flag    = (rx_level > thr_cnt);
    assign status.rx_fifo_level     = rx_level;
    assign status.rx_overflow_flag  = ovf_q;
    assign status.rx_irq_flag       = rxirq_q;
    assign status.tx_irq_flag       = txirq_q;
    assign status.tx_underflow_flag = uf_q;
    assign status.tx_fifo_level     = tx_level;
    assign status.any_irq_flag      = any_q;

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    // Writing a one clears a bit; an event in the same cycle keeps it set.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_stat_q <= IRQ_RESET;
        end else if (acc_wr && AVS_ADDRESS_I == OFF_IRQ_STAT && AVS_BYTEENABLE_I[0]) begin
            irq_stat_q <= (irq_stat_q & ~AVS_WRITEDATA_I[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Mask bits gate only the pin; the status bits still collect events.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_mask_q <= IRQ_RESET;
        end else if (acc_wr && AVS_ADDRESS_I == OFF_IRQ_MASK && AVS_BYTEENABLE_I[0]) begin
            irq_mask_q <= AVS_WRITEDATA_I[IRQ_W-1:0];
        end
    end

    // The pin is an OR of register bits, so it cannot glitch on bus decoding.
    assign IRQ_O = |(irq_stat_q & irq_mask_q);
endmodule : ssf_status_flags

// >>> ssf_status_flags_properties.sv
// Purpose: Concurrent checks on the ports of the SPI status block.
// Assumes: One master on the register bus; threshold and mask are tracked from writes.
// Notes:   Status snapshots are judged at the edge that completes a status read.
// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module ssf_status_flags_properties
    import ssf_pkg::*;
(
    input  wire logic                       CLK_I,
    input  wire logic                       SYS_RST_I,
    input  wire logic [ssf_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                       AVS_READ_I,
    input  wire logic                       AVS_WRITE_I,
    input  wire logic [ssf_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
    input  wire logic [ssf_pkg::BE_W-1:0]   AVS_BYTEENABLE_I,
    input  wire logic [ssf_pkg::DATA_W-1:0] AVS_READDATA_O,
    input  wire logic                       AVS_WAITREQUEST_O,
    input  wire logic                       SPI_SCLK_I,
    input  wire logic                       SPI_CS_N_I,
    input  wire logic                       IRQ_O
);
    import ssf_pkg::*;

    logic [THR_W-1:0] thr_q;
    logic [IRQ_W-1:0] mask_q;
    logic [3:0]       idle_q;
    logic             clean_q;
    wire logic        st_done = AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == OFF_STATUS;
    wire logic        wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            thr_q  <= '0;
            mask_q <= '0;
        end else if (wr_done && AVS_ADDRESS_I == OFF_CONTROL && AVS_BYTEENABLE_I[1]) begin
            thr_q  <= AVS_WRITEDATA_I[15:14];
        end else if (wr_done && AVS_ADDRESS_I == OFF_IRQ_MASK && AVS_BYTEENABLE_I[0]) begin
            mask_q <= AVS_WRITEDATA_I[3:0];
        end
    end

    // A snapshot counts as quiet only when the link has rested long enough for events to land.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            idle_q  <= 4'h0;
            clean_q <= 1'b0;
        end else if (!SPI_CS_N_I) begin
            idle_q  <= 4'h0;
            clean_q <= 1'b0;
        end else begin
            idle_q  <= (idle_q == 4'hf) ? idle_q : idle_q + 4'h1;
            clean_q <= st_done ? (idle_q == 4'hf) : clean_q;
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    wait_once_a: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("read not answered after one wait state");
    upper_zero_a: assert property (st_done |-> AVS_READDATA_O[31:12] == '0)
        else $error("reserved status bits not zero");
    rx_level_a: assert property (st_done |-> AVS_READDATA_O[10:8] <= LVL_FULL)
        else $error("rx level out of range");
    tx_level_a: assert property (st_done |-> AVS_READDATA_O[3:1] <= LVL_FULL)
        else $error("tx level out of range");
    rx_excess_a: assert property (st_done |-> AVS_READDATA_O[11] ==
        (AVS_READDATA_O[10:8] > ({1'b0, thr_q} + 3'h1))) else $error("excess flag wrong");
    read_clear_a: assert property (st_done && clean_q |-> AVS_READDATA_O[7:4] == 4'h0
        && !AVS_READDATA_O[0]) else $error("flags survived a status read");
    summary_a: assert property (st_done && (AVS_READDATA_O[6] || AVS_READDATA_O[5])
        |-> AVS_READDATA_O[0]) else $error("summary flag missing");
    irq_mask_a: assert property (mask_q == '0 |-> !IRQ_O)
        else $error("interrupt raised while all masked");
endmodule : ssf_status_flags_properties

bind ssf_status_flags ssf_status_flags_properties chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .SPI_SCLK_I(SPI_SCLK_I), .SPI_CS_N_I(SPI_CS_N_I), .IRQ_O(IRQ_O));

// >>> ssf_spi_master.sv
// Purpose: Behavioural external SPI master driving clock and select.
// Assumes: Clock idles low; each bit ends on a rising edge.
// Notes:   The clock stands still outside frames; a gap slows the master down.
// ----------------------------------------------------------------------------
// Link model
// ----------------------------------------------------------------------------
module ssf_spi_master (
    output logic sclk_o,
    output logic cs_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end

    // A period count that is not a multiple of eight aborts the last byte.
    task automatic send(input int nbits, input int gap);
        cs_n_o = 1'b0;
        #(gap + 37);
        for (int b = 0; b < nbits; b++) begin
            sclk_o = 1'b1;
            #100;
            sclk_o = 1'b0;
            #100;
            if (b % 8 == 7) #(gap);
        end
        #(gap + 40);
        cs_n_o = 1'b1;
        #300;
    endtask : send
endmodule : ssf_spi_master

// >>> spi_status_flags_test.sv
// Purpose: Self-checking bench of the SPI status block.
// Assumes: Register bus with waitrequest; external master at 200 ns per bit.
// Notes:   Random traffic from a fixed xorshift seed, then a second reset.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module spi_status_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ssf_pkg::*;

    logic              clk, rst, rd, wr, irq, waitreq, sclk, cs_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [31:0]       seed = 32'h0000bfa1;
    int                n_mismatch = 0;
    int                samples_checked = 0;

    ssf_status_flags dut_u (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'h3),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .SPI_SCLK_I(sclk),
        .SPI_CS_N_I(cs_n), .IRQ_O(irq));
    ssf_spi_master master_u (.sclk_o(sclk), .cs_n_o(cs_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Returns the interrupt status nibble above the expected status word.
    function automatic logic [19:0] exp_calc(int n, int k, int p, int c, int md, int rf, int tf);
        int         rl, tl, ne;
        logic       ov, ri, ti, uf;
        logic [3:0] iq;
        ne = tf ? 0 : n;
        rl = rf ? 0 : (k > 4 ? 4 : k);
        tl = ne > k ? ne - k : 0;
        ov = rf == 0 && k > 4;
        ri = md == 0 && rf == 0 && rl > c;
        ti = md == 1 && k > c;
        uf = k > ne || (p > 0 && k >= ne);
        iq = {uf && tf == 0, ov, ti, ri};
        return {iq, 4'h0, rl > c + 1, 3'(rl), ov, ri, ti, uf, 3'(tl), |iq};
    endfunction : exp_calc

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] wd,
                       output logic [DATA_W-1:0] q);
        int i;
        addr  <= a;
        wdata <= {16'h0000, wd};
        rd    <= !w;
        wr    <= w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitreq !== 1'b0 && i < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
        @(posedge clk);
    endtask : bus

    initial begin
        logic [31:0] r, d;
        logic [19:0] e;
        logic [15:0] ctl;
        int          n, k, p, md, rf, tf;
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFF_STATUS, 16'h0000, d);
        `CHK("reset status", 32'h0, d);
        bus(1'b1, OFF_STATUS, 16'hffff, d);
        bus(1'b0, OFF_STATUS, 16'h0000, d);
        `CHK("status after write", 32'h0, d);
        bus(1'b0, 12'h0fc, 16'h0000, d);
        `CHK("unmapped read", 32'h0, d);
        for (int it = 0; it < 24; it++) begin
            r = xs();
            md = r[0];
            rf = r[3:1] == 3'h0;
            tf = r[6:4] == 3'h0;
            n = r[9:7] % 5;
            k = 1 + r[12:10] % 5;
            p = r[13] ? r[16:14] : 0;
            ctl = {2'(it % 4), 1'(tf), 1'(rf), 5'h00, 1'(md), 6'h00};
            bus(1'b1, OFF_CONTROL, ctl, d);
            bus(1'b0, OFF_CONTROL, 16'h0000, d);
            `CHK("control", ctl & CTL_WMASK, d);
            bus(1'b1, OFF_IRQ_MASK, {12'h000, r[20:17]}, d);
            repeat (n) bus(1'b1, OFF_TXDATA, r[31:16], d);
            master_u.send(8 * k + p, r[21] ? 0 : 400);
            repeat (20) @(posedge clk);
            e = exp_calc(n, k, p, it % 4, md, rf, tf);
            bus(1'b0, OFF_IRQ_STAT, 16'h0000, d);
            `CHK("irq status", {28'h0, e[19:16]}, d);
            `CHK("irq pin", |(e[19:16] & r[20:17]), irq);
            bus(1'b0, OFF_STATUS, 16'h0000, d);
            `CHK("status", {16'h0, e[15:0]}, d);
            bus(1'b1, OFF_IRQ_STAT, 16'h000f, d);
            `CHK("irq cleared", 1'b0, irq);
            bus(1'b0, OFF_STATUS, 16'h0000, d);
            `CHK("status reread", {16'h0, e[15:0] & 16'h0f0e}, d);
            bus(1'b0, OFF_RXDATA, 16'h0000, d);
            `CHK("rx data", 32'h0, d);
            n = (e[10:8] == 3'h0) ? 0 : e[10:8] - 1;
            bus(1'b0, OFF_STATUS, 16'h0000, d);
            `CHK("pop status", {20'h0, n > it % 4 + 1, 3'(n), 4'h0, e[3:1], 1'b0}, d);
            bus(1'b1, OFF_CONTROL, 16'h3000, d);
        end
        bus(1'b1, OFF_CONTROL, 16'hc040, d);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFF_CONTROL, 16'h0000, d);
        `CHK("control after reset", 32'h0, d);
        complete_run();
    end
endmodule : spi_status_flags_test
